// ### probe_capture_model.sv
`timescale 1ns/1ps

// observation equipment on the monitor pin: collects framed bits, flags stray highs
module probe_capture_model (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic clear_in,
    // monitor pin
    input wire logic serial_in,
    input wire logic frame_in,
    // capture results
    output logic [39:0] cap_out,
    output logic [7:0] nbits_out,
    output logic [7:0] stray_out
);
    // a high level outside a frame is counted, since the pin must rest low
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cap_out <= 40'h0;
            nbits_out <= 8'h00;
            stray_out <= 8'h00;
        end
        else if (clear_in)
        begin
            cap_out <= 40'h0;
            nbits_out <= 8'h00;
            stray_out <= 8'h00;
        end
        else if (frame_in)
        begin
            cap_out <= {cap_out[38:0], serial_in};
            nbits_out <= nbits_out + 8'h01;
        end
        else if (serial_in !== 1'b0)
        begin
            stray_out <= stray_out + 8'h01;
        end
    end
endmodule : probe_capture_model

// ### realtime_probe_monitor.sv
`timescale 1ns/1ps
`include "realtime_probe_monitor_defs.svh"


////////////////////////////////////////////////////////////////////////////////

module probe_word_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic flush_in,
    // fill side
    input wire logic [WIDTH-1:0] fill_data_in,
    input wire logic fill_valid_in,
    output logic fill_ready_out,
    // drain side
    output logic [WIDTH-1:0] drain_data_out,
    output logic drain_valid_out,
    input wire logic drain_ready_in
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_fifo_shape
        $error("probe_word_fifo: depth must be a power of two >= 2");
    end

    typedef struct packed {
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
    } fifo_state_type;

    fifo_state_type q;
    fifo_state_type d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push;
    logic pop;

    assign fill_ready_out = (q.count != (PTR_W + 1)'(DEPTH));
    assign drain_valid_out = (q.count != '0);
    assign drain_data_out = mem_q[q.rd_ptr];
    assign push = fill_valid_in && fill_ready_out && !flush_in;
    assign pop = drain_valid_out && drain_ready_in && !flush_in;

    always_comb
    begin
        d = q;
        if (flush_in)
        begin
            d = '0;
        end
        else
        begin
            d.wr_ptr = q.wr_ptr + PTR_W'(push);
            d.rd_ptr = q.rd_ptr + PTR_W'(pop);
            d.count = q.count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // storage has no reset; only words below count are ever read
    always_ff @(posedge sys_clk_in)
    begin
        if (push)
        begin
            mem_q[q.wr_ptr] <= fill_data_in;
        end
    end
endmodule : probe_word_fifo

////////////////////////////////////////////////////////////////////////////////

module realtime_probe_monitor #(
    parameter int FIFO_DEPTH = `MON_FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // compute engine
    input wire logic ce_pass_start_in,
    output logic ce_pass_hold_out,
    // monitor pin
    output logic monitor_serial_out,
    output logic monitor_frame_out
);
    localparam int WB = `MON_WORD_BITS;

    if (FIFO_DEPTH < `MON_PROBE_COUNT)
    begin : g_bad_fifo_depth
        $error("realtime_probe_monitor: fifo must hold all four probes");
    end

    realtime_probe_monitor_pkg::mon_state_vec_type q;
    realtime_probe_monitor_pkg::mon_state_vec_type d;
    realtime_probe_monitor_pkg::reg_req_type req;
    logic [WB-1:0] fill_word;
    logic fill_valid;
    logic fill_ready;
    logic [WB-1:0] drain_word;
    logic drain_valid;
    logic drain_ready;
    logic flush;

    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    always_comb
    begin
        unique case (q.load_idx)
            2'h0: fill_word = {q.probe0_high, q.probe0_low};
            2'h1: fill_word = {2'h0, q.probe1};
            2'h2: fill_word = {2'h0, q.probe2};
            2'h3: fill_word = {2'h0, q.probe3};
        endcase
    end

    assign fill_valid = (q.state == realtime_probe_monitor_pkg::MON_LOAD) && q.enable;
    // shifter stalls the fifo until the current word is out
    assign drain_ready = q.enable && (q.shift_cnt == 4'h0);
    assign flush = !d.enable;

    probe_word_fifo #(
        .WIDTH(WB),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .flush_in(flush),
        .fill_data_in(fill_word),
        .fill_valid_in(fill_valid),
        .fill_ready_out(fill_ready),
        .drain_data_out(drain_word),
        .drain_valid_out(drain_valid),
        .drain_ready_in(drain_ready)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        d = q;
        d.rdata = 8'h00;
        // register writes
        if (req.wr)
        begin
            unique case (req.addr)
                `MON_ENABLE_CTL_OFF: d.enable = req.wdata[`MON_ENABLE_BIT];
                `MON_PROBE0_HIGH_OFF: d.probe0_high = req.wdata[1:0];
                `MON_PROBE0_LOW_OFF: d.probe0_low = req.wdata;
                `MON_PROBE1_OFF: d.probe1 = req.wdata;
                `MON_PROBE2_OFF: d.probe2 = req.wdata;
                `MON_PROBE3_OFF: d.probe3 = req.wdata;
                `MON_STATUS_OFF:
                begin
                    if (req.wdata[`MON_STAT_MISSED_BIT])
                    begin
                        d.missed = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // register reads, unmapped reads return zero
        if (req.rd)
        begin
            unique case (req.addr)
                `MON_ENABLE_CTL_OFF: d.rdata[`MON_ENABLE_BIT] = q.enable;
                `MON_PROBE0_HIGH_OFF: d.rdata[1:0] = q.probe0_high;
                `MON_PROBE0_LOW_OFF: d.rdata = q.probe0_low;
                `MON_PROBE1_OFF: d.rdata = q.probe1;
                `MON_PROBE2_OFF: d.rdata = q.probe2;
                `MON_PROBE3_OFF: d.rdata = q.probe3;
                `MON_STATUS_OFF:
                begin
                    d.rdata[`MON_STAT_BUSY_BIT] = q.hold;
                    d.rdata[`MON_STAT_MISSED_BIT] = q.missed;
                end
                default: ;
            endcase
        end
        // sequencer
        unique case (q.state)
            realtime_probe_monitor_pkg::MON_IDLE:
            begin
                if (ce_pass_start_in && q.enable)
                begin
                    d.state = realtime_probe_monitor_pkg::MON_LOAD;
                    d.load_idx = 2'h0;
                end
            end
            realtime_probe_monitor_pkg::MON_LOAD:
            begin
                if (fill_ready)
                begin
                    d.load_idx = q.load_idx + 2'h1;
                    if (q.load_idx == 2'(`MON_PROBE_COUNT - 1))
                    begin
                        d.state = realtime_probe_monitor_pkg::MON_DRAIN;
                    end
                end
            end
            realtime_probe_monitor_pkg::MON_DRAIN:
            begin
                if (!drain_valid && q.shift_cnt == 4'h0)
                begin
                    d.state = realtime_probe_monitor_pkg::MON_IDLE;
                end
            end
        endcase
        // a pass that begins while a frame is still going is not sent
        if (ce_pass_start_in && q.enable && q.state != realtime_probe_monitor_pkg::MON_IDLE)
        begin
            d.missed = 1'b1;
        end
        if (q.shift_cnt != 4'h0)
        begin
            d.serial = q.shift_data[WB-1];
            d.shift_data = {q.shift_data[WB-2:0], 1'b0};
            d.shift_cnt = q.shift_cnt - 4'h1;
            d.frame = 1'b1;
        end
        else if (drain_valid && drain_ready)
        begin
            d.serial = drain_word[WB-1];
            d.shift_data = {drain_word[WB-2:0], 1'b0};
            d.shift_cnt = 4'(WB - 1);
            d.frame = 1'b1;
        end
        else
        begin
            d.serial = 1'b0;
            d.frame = 1'b0;
        end
        if (!d.enable)
        begin
            d.state = realtime_probe_monitor_pkg::MON_IDLE;
            d.shift_cnt = 4'h0;
            d.serial = 1'b0;
            d.frame = 1'b0;
        end
        d.hold = (d.state != realtime_probe_monitor_pkg::MON_IDLE);
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            q <= '{
                enable: `MON_ENABLE_RST,
                probe0_high: `MON_PROBE0_HIGH_RST,
                probe0_low: `MON_PROBE_BYTE_RST,
                probe1: `MON_PROBE_BYTE_RST,
                probe2: `MON_PROBE_BYTE_RST,
                probe3: `MON_PROBE_BYTE_RST,
                missed: 1'b0,
                state: realtime_probe_monitor_pkg::MON_IDLE,
                load_idx: 2'h0,
                shift_data: 10'h000,
                shift_cnt: 4'h0,
                serial: 1'b0,
                frame: 1'b0,
                hold: 1'b0,
                rdata: 8'h00
            };
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata_out = q.rdata;
    assign ce_pass_hold_out = q.hold;
    assign monitor_serial_out = q.serial;
    assign monitor_frame_out = q.frame;

    ////////////////////////////////////////////////////////////////////////////

    // checking helpers: bit position in frame and captured probe zero top bits
    logic [5:0] frame_pos_q;
    logic [1:0] cap_high_q;

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            frame_pos_q <= 6'h00;
            cap_high_q <= 2'h0;
        end
        else
        begin
            frame_pos_q <= q.frame ? frame_pos_q + 6'h01 : 6'h00;
            if (fill_valid && fill_ready && q.load_idx == 2'h0)
            begin
                cap_high_q <= q.probe0_high;
            end
        end
    end

    default clocking mon_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_pin_low_disabled: assert property (!q.enable |-> !monitor_serial_out)
        else $error("monitor pin not low while disabled");
    a_no_frame_disabled: assert property (!q.enable |-> !monitor_frame_out && !ce_pass_hold_out)
        else $error("probe output while disabled");
    a_pass_starts_load: assert property (
        q.enable && q.state == realtime_probe_monitor_pkg::MON_IDLE && ce_pass_start_in && !reg_wr_in
        |=> ce_pass_hold_out ##[1:4] (monitor_frame_out || !q.enable))
        else $error("pass start did not begin a probe frame");
    a_frame_forty_bits: assert property ($fell(monitor_frame_out) && q.enable |-> $past(frame_pos_q) == 6'd39)
        else $error("probe frame not forty bits long");
    a_probe0_top_bits: assert property (
        $rose(monitor_frame_out) |-> (monitor_serial_out == cap_high_q[1] || !q.enable)
        ##1 (monitor_serial_out == cap_high_q[0] || !q.enable))
        else $error("probe zero top bits wrong");
    a_upper_bits_zero: assert property (
        monitor_frame_out && frame_pos_q inside {6'd10, 6'd11, 6'd20, 6'd21, 6'd30, 6'd31}
        |-> !monitor_serial_out)
        else $error("probe one to three top bits not zero");
    a_bit_per_clock: assert property (q.shift_cnt != 4'h0 && d.enable |=> monitor_frame_out)
        else $error("shifter skipped a clock");
    a_frame_under_hold: assert property (monitor_frame_out |-> ce_pass_hold_out)
        else $error("frame outside engine hold");
    a_enable_readback: assert property (
        reg_rd_in && reg_addr_in == `MON_ENABLE_CTL_OFF
        |=> reg_rdata_out == {6'h00, $past(q.enable), 1'b0})
        else $error("enable readback wrong");
endmodule : realtime_probe_monitor

// ### realtime_probe_monitor_defs.svh
`ifndef REALTIME_PROBE_MONITOR_DEFS_SVH
`define REALTIME_PROBE_MONITOR_DEFS_SVH

// register byte addresses
`define MON_ENABLE_CTL_OFF 16'h2106
`define MON_PROBE0_HIGH_OFF 16'h210d
`define MON_PROBE0_LOW_OFF 16'h210e
`define MON_PROBE1_OFF 16'h210f
`define MON_PROBE2_OFF 16'h2110
`define MON_PROBE3_OFF 16'h2111
`define MON_STATUS_OFF 16'h2112

// field positions
`define MON_ENABLE_BIT 1
`define MON_STAT_BUSY_BIT 0
`define MON_STAT_MISSED_BIT 1

// reset values
`define MON_ENABLE_RST 1'h0
`define MON_PROBE0_HIGH_RST 2'h0
`define MON_PROBE_BYTE_RST 8'h00

// serial frame shape
`define MON_PROBE_COUNT 4
`define MON_WORD_BITS 10
`define MON_FIFO_DEPTH 4

`endif

// ### realtime_probe_monitor_pkg.sv
package realtime_probe_monitor_pkg;

    typedef enum logic [1:0] {
        MON_IDLE,
        MON_LOAD,
        MON_DRAIN
    } mon_state_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic enable;
        logic [1:0] probe0_high;
        logic [7:0] probe0_low;
        logic [7:0] probe1;
        logic [7:0] probe2;
        logic [7:0] probe3;
        logic missed;
        mon_state_type state;
        logic [1:0] load_idx;
        logic [9:0] shift_data;
        logic [3:0] shift_cnt;
        logic serial;
        logic frame;
        logic hold;
        logic [7:0] rdata;
    } mon_state_vec_type;

endpackage : realtime_probe_monitor_pkg

// ### testbench.sv
`timescale 1ns/1ps
`include "realtime_probe_monitor_defs.svh"

module testbench;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic ce_pass_start_in = 1'b0;
    logic ce_pass_hold_out;
    logic monitor_serial_out;
    logic monitor_frame_out;
    logic clear = 1'b0;
    logic [39:0] cap;
    logic [7:0] nbits;
    logic [7:0] stray;
    logic [7:0] rd;
    int err_count = 0;
    int n_tests = 0;

    realtime_probe_monitor uut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .ce_pass_start_in(ce_pass_start_in), .ce_pass_hold_out(ce_pass_hold_out),
        .monitor_serial_out(monitor_serial_out), .monitor_frame_out(monitor_frame_out));
    probe_capture_model observer (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clear_in(clear),
        .serial_in(monitor_serial_out), .frame_in(monitor_frame_out), .cap_out(cap), .nbits_out(nbits),
        .stray_out(stray));

    initial
    begin
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe edge
    task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : reg_read

    task automatic pass_start();
        @(posedge sys_clk_in);
        ce_pass_start_in <= 1'b1;
        @(posedge sys_clk_in);
        ce_pass_start_in <= 1'b0;
    endtask : pass_start

    // bounded wait for a whole frame and the hold to drop
    task automatic wait_frame();
        int i;
        for (i = 0; i < 100 && !(nbits == 8'd40 && ce_pass_hold_out === 1'b0); i++)
            @(posedge sys_clk_in);
        #1;
    endtask : wait_frame

    task automatic clear_cap();
        @(posedge sys_clk_in);
        clear <= 1'b1;
        @(posedge sys_clk_in);
        clear <= 1'b0;
    endtask : clear_cap

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #80000;
        err_count++;
        $display("watchdog expired");
        finish_test();
    end

    initial
    begin
        logic [15:0] addrs [8];
        logic [39:0] exp;
        addrs = '{`MON_ENABLE_CTL_OFF, `MON_PROBE0_HIGH_OFF, `MON_PROBE0_LOW_OFF, `MON_PROBE1_OFF,
            `MON_PROBE2_OFF, `MON_PROBE3_OFF, `MON_STATUS_OFF, 16'h2120};
        repeat (10) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        // every register and an unmapped place read zero after reset
        foreach (addrs[i])
        begin
            reg_read(addrs[i], rd);
            check("reset value", 40'h0, {32'h0, rd});
        end
        reg_write(16'h2120, 8'hff);
        reg_read(16'h2120, rd);
        check("unmapped", 40'h0, {32'h0, rd});
        $display("test reset values done");

        // disabled: start is ignored and the pin rests low
        reg_write(`MON_PROBE0_LOW_OFF, 8'hff);
        pass_start();
        repeat (50) @(posedge sys_clk_in);
        check("bits while disabled", 40'h0, {32'h0, nbits});
        check("stray while disabled", 40'h0, {32'h0, stray});
        $display("test disabled done");

        // probe values with distinct bit patterns
        reg_write(`MON_PROBE0_HIGH_OFF, 8'hfe);
        reg_write(`MON_PROBE0_LOW_OFF, 8'h5a);
        reg_write(`MON_PROBE1_OFF, 8'hc3);
        reg_write(`MON_PROBE2_OFF, 8'h81);
        reg_write(`MON_PROBE3_OFF, 8'h7e);
        reg_read(`MON_PROBE0_HIGH_OFF, rd);
        check("probe0 high width", 40'h02, {32'h0, rd});
        reg_write(`MON_ENABLE_CTL_OFF, 8'hff);
        reg_read(`MON_ENABLE_CTL_OFF, rd);
        check("enable readback", 40'h02, {32'h0, rd});
        exp = {2'b10, 8'h5a, 2'b00, 8'hc3, 2'b00, 8'h81, 2'b00, 8'h7e};
        // one full frame per pass, twice back to back
        repeat (2)
        begin
            clear_cap();
            pass_start();
            #1 check("hold after start", 40'h1, {39'h0, ce_pass_hold_out});
            wait_frame();
            check("frame bits", 40'd40, {32'h0, nbits});
            check("frame data", exp, cap);
            check("stray enabled", 40'h0, {32'h0, stray});
        end
        $display("test frame done");

        // second start while busy is refused and marked
        clear_cap();
        pass_start();
        repeat (5) @(posedge sys_clk_in);
        pass_start();
        reg_read(`MON_STATUS_OFF, rd);
        check("busy and missed", 40'h03, {32'h0, rd});
        wait_frame();
        check("single frame", 40'd40, {32'h0, nbits});
        reg_read(`MON_STATUS_OFF, rd);
        check("missed set", 40'h02, {32'h0, rd});
        reg_write(`MON_STATUS_OFF, 8'h02);
        reg_read(`MON_STATUS_OFF, rd);
        check("missed cleared", 40'h0, {32'h0, rd});
        $display("test missed done");

        // clearing enable mid-frame drops the pin at once
        clear_cap();
        pass_start();
        repeat (12) @(posedge sys_clk_in);
        reg_write(`MON_ENABLE_CTL_OFF, 8'h00);
        @(posedge sys_clk_in);
        #1 check("pin after abort", 40'h0, {37'h0, monitor_serial_out, monitor_frame_out, ce_pass_hold_out});
        check("bits before abort", 40'd12, {32'h0, nbits});
        clear_cap();
        pass_start();
        repeat (60) @(posedge sys_clk_in);
        check("bits after abort", 40'h0, {32'h0, nbits});
        check("stray after abort", 40'h0, {32'h0, stray});
        $display("test abort done");
        finish_test();
    end
endmodule : testbench
